// ---- shared/tsm_pkg.sv ----
package tsm_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_FIRST_STATUS = 8'h20;
	localparam logic [7:0] IDX_SECOND_STATUS = 8'h21;
	localparam logic [7:0] IDX_CV_HIGH = 8'h23;
	localparam logic [7:0] IDX_CV_LOW = 8'h24;
	localparam logic [7:0] IDX_SECOND_MASK = 8'h6F;
	localparam logic [7:0] IDX_FIRST_MASK = 8'h7F;
	localparam logic [7:0] IDX_CONTROL = 8'h40;
	localparam logic [7:0] IDX_MATCH_ONE = 8'h41;
	localparam logic [7:0] IDX_MATCH_TWO = 8'h42;

	// Second status byte bit positions
	localparam int BIT_RX_MF = 7;
	localparam int BIT_TX_MF = 6;
	localparam int BIT_SEC = 5;
	localparam int BIT_RX_FULL = 4;
	localparam int BIT_TX_EMPTY = 3;
	localparam int BIT_MATCH = 2;
	localparam int BIT_ABORT = 1;
	localparam int BIT_SIG_CHG = 0;

	// Control register bit positions
	localparam int CTL_INTERVAL_SEL = 2;
	localparam int CTL_ZERO_SUB = 1;
	localparam int CTL_EXCESS_ZERO = 0;

	// Values after reset
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_MATCH = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [3:0] RST_SIG = 4'h0;

	// Excessive zero run lengths, abort ones run and link byte length
	localparam logic [4:0] ZERO_RUN_PLAIN = 5'h10;
	localparam logic [4:0] ZERO_RUN_SUB = 5'h08;
	localparam logic [3:0] ONES_ABORT = 4'h8;
	localparam logic [3:0] LINK_BYTE_BITS = 4'h8;

	// Timing
	localparam int CLK_KHZ = 10000;
	localparam int SEC_SHORT_MS = 999;
	localparam int SEC_LONG_MS = 1002;
	localparam int FAST_INTERVAL_MS = 42;
	localparam int SEC_SHORT_CYC = SEC_SHORT_MS * CLK_KHZ;
	localparam int SEC_LONG_CYC = SEC_LONG_MS * CLK_KHZ;
	localparam int FAST_INTERVAL_CYC = FAST_INTERVAL_MS * CLK_KHZ;
	localparam logic [1:0] SEC_PHASES = 2'h2;
endpackage : tsm_pkg

// ---- hw/tsm_cnt_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsm_cnt_latch (
	input wire logic mclk, // Clock
	input wire logic rst, // Async reset, high
	input wire logic [1:0] inc, // Violations this cycle
	input wire logic boundary, // Update boundary pulse
	output logic [15:0] held // Count of previous interval
);
	logic [15:0] acc_r;
	logic [15:0] acc_nxt;
	logic [15:0] held_r;
	logic [15:0] held_nxt;
	logic [16:0] sum;

	always_comb begin
		sum = {1'b0, acc_r} + {15'h0000, inc};
		held_nxt = held_r;
		if (boundary) begin
			held_nxt = acc_r; // RULE_10
			// Events on the boundary edge open the next interval
			acc_nxt = {14'h0000, inc};
		end else if (sum[16]) begin
			acc_nxt = 16'hFFFF; // RULE_12
		end else begin
			acc_nxt = sum[15:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acc_r <= tsm_pkg::RST_COUNT;
			held_r <= tsm_pkg::RST_COUNT;
		end else begin
			acc_r <= acc_nxt;
			held_r <= held_nxt;
		end
	end

	assign held = held_r;
endmodule : tsm_cnt_latch
`default_nettype wire

// ---- hw/tsm_top.sv ----
// Notes on behaviour
// RULE_01: Multiframe boundaries set top two status bits
// RULE_02: One-second tick: 999, 999, 1002 ms cycle
// RULE_03: Eight collected link bits set buffer full
// RULE_04: Transmit link buffer emptying sets flag
// RULE_05: Received link byte matching either byte flags
// RULE_06: Eight consecutive link ones flag abort
// RULE_07: First mask gates first status, 1 enables
// RULE_08: Second mask mirrors second status, 1 enables
// RULE_09: Counters update per second or 42 ms
// RULE_10: Previous interval count held whole next interval
// RULE_11: Host reads counters within one interval
// RULE_12: Counters saturate at maximum, never wrap
// RULE_13: Sixteen-bit count, high 0x23, low 0x24
// RULE_14: Count bipolar violations, optionally excess zeros
// RULE_15: Valid substitution codewords not counted as violations
// RULE_16: Violation counter runs even during sync loss
// RULE_17: Excess zeros: 16 plain, 8 with substitution
// RULE_18: First status byte at 0x20, mask order
// RULE_19: Interrupt when any enabled status bit set
// RULE_20: Signaling value change sets signaling flag
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tsm_top #(
	parameter int SEC_SHORT_CYC = tsm_pkg::SEC_SHORT_CYC, // 999 ms in cycles
	parameter int SEC_LONG_CYC = tsm_pkg::SEC_LONG_CYC, // 1002 ms in cycles
	parameter int FAST_CYC = tsm_pkg::FAST_INTERVAL_CYC // 42 ms in cycles
) (
	input wire logic mclk, // Receive-derived clock
	input wire logic rst, // Async reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [7:0] first_status_cond, // Loop up..sync loss levels
	input wire logic rx_mf_boundary, // Receive multiframe pulse
	input wire logic tx_mf_boundary, // Transmit multiframe pulse
	input wire logic rx_link_bit_valid, // Link bit strobe
	input wire logic rx_link_bit, // Link bit value
	input wire logic tx_link_empty, // Transmit link buffer empty level
	input wire logic rx_sig_strobe, // Signaling value strobe
	input wire logic [3:0] rx_sig_value, // Robbed-bit signaling value
	input wire logic bpv_pulse, // Bipolar violation seen
	input wire logic zero_sub_codeword, // Valid substitution codeword seen
	input wire logic line_bit_valid, // Line bit strobe
	input wire logic line_bit_zero, // Line bit is a zero
	output logic irq // Interrupt, high
);
	// Bus slave
	logic access;
	logic wr_done;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic [7:0] rdata;
	logic mapped;

	// Registers
	logic [7:0] first_status_r;
	logic [7:0] first_status_nxt;
	logic [7:0] second_status_r;
	logic [7:0] second_status_nxt;
	logic [7:0] first_mask_r;
	logic [7:0] first_mask_nxt;
	logic [7:0] second_mask_r;
	logic [7:0] second_mask_nxt;
	logic [7:0] control_r;
	logic [7:0] control_nxt;
	logic [7:0] match_one_r;
	logic [7:0] match_one_nxt;
	logic [7:0] match_two_r;
	logic [7:0] match_two_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [7:0] sec_set;

	// Timers
	logic [23:0] sec_cnt_r;
	logic [23:0] sec_cnt_nxt;
	logic [1:0] sec_phase_r;
	logic [1:0] sec_phase_nxt;
	logic [23:0] fast_cnt_r;
	logic [23:0] fast_cnt_nxt;
	logic sec_tick;
	logic fast_tick;
	logic boundary;

	// Link and signaling
	logic [7:0] link_shift_r;
	logic [7:0] link_shift_nxt;
	logic [3:0] link_bits_r;
	logic [3:0] link_bits_nxt;
	logic [3:0] ones_run_r;
	logic [3:0] ones_run_nxt;
	logic tx_empty_d_r;
	logic [3:0] sig_r;
	logic [3:0] sig_nxt;
	logic link_full;
	logic link_match;
	logic link_abort;
	logic sig_change;

	// Violations
	logic [4:0] zero_run_r;
	logic [4:0] zero_run_nxt;
	logic [4:0] zero_thr;
	logic ez_event;
	logic bpv_event;
	logic [15:0] cv_held;

	function automatic logic is_mapped(input logic [7:0] i);
		case (i)
			tsm_pkg::IDX_FIRST_STATUS, tsm_pkg::IDX_SECOND_STATUS,
			tsm_pkg::IDX_CV_HIGH, tsm_pkg::IDX_CV_LOW,
			tsm_pkg::IDX_SECOND_MASK, tsm_pkg::IDX_FIRST_MASK,
			tsm_pkg::IDX_CONTROL, tsm_pkg::IDX_MATCH_ONE,
			tsm_pkg::IDX_MATCH_TWO: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Bus slave: one wait state, the cycle after the first access cycle completes
	always_comb begin
		access = psel & penable;
		idx = paddr[9:2];
		mapped = is_mapped(idx) & (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
		wr_done = access & pready_r & pwrite & mapped & pstrb[0];
		wbyte = pwdata[7:0];
		case (idx)
			tsm_pkg::IDX_FIRST_STATUS: rdata = first_status_r; // RULE_18
			tsm_pkg::IDX_SECOND_STATUS: rdata = second_status_r;
			tsm_pkg::IDX_CV_HIGH: rdata = cv_held[15:8]; // RULE_13
			tsm_pkg::IDX_CV_LOW: rdata = cv_held[7:0]; // RULE_13
			tsm_pkg::IDX_SECOND_MASK: rdata = second_mask_r;
			tsm_pkg::IDX_FIRST_MASK: rdata = first_mask_r;
			tsm_pkg::IDX_CONTROL: rdata = control_r;
			tsm_pkg::IDX_MATCH_ONE: rdata = match_one_r;
			tsm_pkg::IDX_MATCH_TWO: rdata = match_two_r;
			default: rdata = 8'h00;
		endcase
		pready_nxt = access & ~pready_r;
		pslverr_nxt = access & ~pready_r & ~mapped;
		prdata_nxt = prdata_r;
		if (access & ~pready_r) begin
			prdata_nxt = (mapped & ~pwrite) ? {24'h000000, rdata} : 32'h00000000;
		end
	end

	// One-second tick and 42 ms tick
	always_comb begin
		sec_tick = 1'b0;
		sec_phase_nxt = sec_phase_r;
		sec_cnt_nxt = sec_cnt_r + 24'h000001;
		if (sec_phase_r == tsm_pkg::SEC_PHASES) begin
			sec_tick = (sec_cnt_r == 24'(SEC_LONG_CYC - 1)); // RULE_02
		end else begin
			sec_tick = (sec_cnt_r == 24'(SEC_SHORT_CYC - 1)); // RULE_02
		end
		if (sec_tick) begin
			sec_cnt_nxt = 24'h000000;
			sec_phase_nxt = (sec_phase_r == tsm_pkg::SEC_PHASES) ? 2'h0 : sec_phase_r + 2'h1;
		end
		fast_tick = (fast_cnt_r == 24'(FAST_CYC - 1));
		fast_cnt_nxt = fast_tick ? 24'h000000 : fast_cnt_r + 24'h000001;
		// Both timers run always so switching interval takes effect at once
		boundary = control_r[tsm_pkg::CTL_INTERVAL_SEL] ? fast_tick : sec_tick; // RULE_09
	end

	// Receive link collector, abort, match, signaling
	always_comb begin
		link_shift_nxt = link_shift_r;
		link_bits_nxt = link_bits_r;
		ones_run_nxt = ones_run_r;
		link_full = 1'b0;
		link_abort = 1'b0;
		if (rx_link_bit_valid) begin
			link_shift_nxt = {link_shift_r[6:0], rx_link_bit};
			if (link_bits_r == tsm_pkg::LINK_BYTE_BITS - 4'h1) begin
				link_full = 1'b1; // RULE_03
				link_bits_nxt = 4'h0;
			end else begin
				link_bits_nxt = link_bits_r + 4'h1;
			end
			if (rx_link_bit) begin
				// Flag only on the eighth one; a longer run does not re-flag
				link_abort = (ones_run_r == tsm_pkg::ONES_ABORT - 4'h1); // RULE_06
				ones_run_nxt = (ones_run_r == tsm_pkg::ONES_ABORT) ? ones_run_r : ones_run_r + 4'h1;
			end else begin
				ones_run_nxt = 4'h0;
			end
		end
		link_match = link_full &
			((link_shift_nxt == match_one_r) | (link_shift_nxt == match_two_r)); // RULE_05
		sig_nxt = rx_sig_strobe ? rx_sig_value : sig_r;
		sig_change = rx_sig_strobe & (rx_sig_value != sig_r); // RULE_20
	end

	// Violation events; counting never depends on sync state
	always_comb begin
		zero_thr = control_r[tsm_pkg::CTL_ZERO_SUB] ? tsm_pkg::ZERO_RUN_SUB
			: tsm_pkg::ZERO_RUN_PLAIN; // RULE_17
		zero_run_nxt = zero_run_r;
		ez_event = 1'b0;
		if (line_bit_valid) begin
			if (line_bit_zero) begin
				// One event per run, at the cycle the threshold is reached
				ez_event = control_r[tsm_pkg::CTL_EXCESS_ZERO] &
					(zero_run_r == zero_thr - 5'h01); // RULE_14
				zero_run_nxt = (zero_run_r == zero_thr) ? zero_run_r : zero_run_r + 5'h01;
			end else begin
				zero_run_nxt = 5'h00;
			end
		end
		bpv_event = bpv_pulse &
			~(control_r[tsm_pkg::CTL_ZERO_SUB] & zero_sub_codeword); // RULE_14 RULE_15 RULE_16
	end

	// Status, masks, control, interrupt
	always_comb begin
		sec_set = 8'h00;
		sec_set[tsm_pkg::BIT_RX_MF] = rx_mf_boundary; // RULE_01
		sec_set[tsm_pkg::BIT_TX_MF] = tx_mf_boundary; // RULE_01
		sec_set[tsm_pkg::BIT_SEC] = sec_tick; // RULE_02
		sec_set[tsm_pkg::BIT_RX_FULL] = link_full; // RULE_03
		sec_set[tsm_pkg::BIT_TX_EMPTY] = tx_link_empty & ~tx_empty_d_r; // RULE_04
		sec_set[tsm_pkg::BIT_MATCH] = link_match; // RULE_05
		sec_set[tsm_pkg::BIT_ABORT] = link_abort; // RULE_06
		sec_set[tsm_pkg::BIT_SIG_CHG] = sig_change; // RULE_20
		first_status_nxt = first_status_r;
		second_status_nxt = second_status_r;
		first_mask_nxt = first_mask_r;
		second_mask_nxt = second_mask_r;
		control_nxt = control_r;
		match_one_nxt = match_one_r;
		match_two_nxt = match_two_r;
		// Write-one-to-clear; a new event in the same cycle keeps its bit
		if (wr_done && idx == tsm_pkg::IDX_FIRST_STATUS) begin
			first_status_nxt = first_status_r & ~wbyte;
		end
		if (wr_done && idx == tsm_pkg::IDX_SECOND_STATUS) begin
			second_status_nxt = second_status_r & ~wbyte;
		end
		first_status_nxt = first_status_nxt | first_status_cond; // RULE_18
		second_status_nxt = second_status_nxt | sec_set;
		if (wr_done && idx == tsm_pkg::IDX_FIRST_MASK) begin
			first_mask_nxt = wbyte; // RULE_07
		end
		if (wr_done && idx == tsm_pkg::IDX_SECOND_MASK) begin
			second_mask_nxt = wbyte; // RULE_08
		end
		if (wr_done && idx == tsm_pkg::IDX_CONTROL) begin
			control_nxt = wbyte & 8'h07;
		end
		if (wr_done && idx == tsm_pkg::IDX_MATCH_ONE) begin
			match_one_nxt = wbyte;
		end
		if (wr_done && idx == tsm_pkg::IDX_MATCH_TWO) begin
			match_two_nxt = wbyte;
		end
		irq_nxt = |(first_status_r & first_mask_r) | |(second_status_r & second_mask_r); // RULE_07 RULE_08 RULE_19
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
			first_status_r <= tsm_pkg::RST_STATUS;
			second_status_r <= tsm_pkg::RST_STATUS;
			first_mask_r <= tsm_pkg::RST_MASK;
			second_mask_r <= tsm_pkg::RST_MASK;
			control_r <= tsm_pkg::RST_CONTROL;
			match_one_r <= tsm_pkg::RST_MATCH;
			match_two_r <= tsm_pkg::RST_MATCH;
			irq_r <= 1'b0;
			sec_cnt_r <= 24'h000000;
			sec_phase_r <= 2'h0;
			fast_cnt_r <= 24'h000000;
			link_shift_r <= 8'h00;
			link_bits_r <= 4'h0;
			ones_run_r <= 4'h0;
			tx_empty_d_r <= 1'b0;
			sig_r <= tsm_pkg::RST_SIG;
			zero_run_r <= 5'h00;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			first_status_r <= first_status_nxt;
			second_status_r <= second_status_nxt;
			first_mask_r <= first_mask_nxt;
			second_mask_r <= second_mask_nxt;
			control_r <= control_nxt;
			match_one_r <= match_one_nxt;
			match_two_r <= match_two_nxt;
			irq_r <= irq_nxt;
			sec_cnt_r <= sec_cnt_nxt;
			sec_phase_r <= sec_phase_nxt;
			fast_cnt_r <= fast_cnt_nxt;
			link_shift_r <= link_shift_nxt;
			link_bits_r <= link_bits_nxt;
			ones_run_r <= ones_run_nxt;
			tx_empty_d_r <= tx_link_empty;
			sig_r <= sig_nxt;
			zero_run_r <= zero_run_nxt;
		end
	end

	tsm_cnt_latch u_cv (
		.mclk(mclk),
		.rst(rst),
		.inc({1'b0, bpv_event} + {1'b0, ez_event}), // RULE_14
		.boundary(boundary), // RULE_09 RULE_10
		.held(cv_held)
	);

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
endmodule : tsm_top
`default_nettype wire

// ---- testbench/tsm_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsm_checker (
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [3:0] pstrb, // Strobes
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic irq // Interrupt
);
	logic [7:0] m1_r, m2_r, m1_nxt, m2_nxt;
	logic done, mapped;
	assign done = psel && penable && pready;
	assign mapped = paddr inside {12'h080, 12'h084, 12'h08C, 12'h090, 12'h1BC, 12'h1FC,
		12'h100, 12'h104, 12'h108};
	// Shadow of both masks, updated at the same edge as the slave's own copy
	always_comb begin
		m1_nxt = m1_r;
		m2_nxt = m2_r;
		if (done && pwrite && pstrb[0] && paddr == 12'h1FC) m1_nxt = pwdata[7:0];
		if (done && pwrite && pstrb[0] && paddr == 12'h1BC) m2_nxt = pwdata[7:0];
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			m1_r <= 8'h00;
			m2_r <= 8'h00;
		end else begin
			m1_r <= m1_nxt;
			m2_r <= m2_nxt;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && !pready; endsequence
	property p_wait; s_setup ##1 s_access |=> pready; endproperty
	a_wait: assert property (p_wait)
		else $error("ready not after one wait state");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse)
		else $error("ready longer than one cycle");
	property p_err; pslverr |-> pready && !mapped; endproperty
	a_err: assert property (p_err)
		else $error("error on a mapped address");
	property p_bad; done && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
	a_bad: assert property (p_bad)
		else $error("unmapped access not refused");
	property p_upper; done && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper)
		else $error("read data above the byte not zero");
	property p_irq1; done && !pwrite && paddr == 12'h080 && |(prdata[7:0] & m1_r) |-> irq; endproperty
	a_irq1: assert property (p_irq1)
		else $error("enabled first status bit without interrupt");
	property p_irq2; done && !pwrite && paddr == 12'h084 && |(prdata[7:0] & m2_r) |-> irq; endproperty
	a_irq2: assert property (p_irq2)
		else $error("enabled second status bit without interrupt");
	property p_quiet; (m1_r == 8'h00 && m2_r == 8'h00)[*3] |-> !irq; endproperty
	a_quiet: assert property (p_quiet)
		else $error("interrupt with all sources masked");
	property p_m1rd; done && !pwrite && paddr == 12'h1FC |-> prdata[7:0] == m1_r; endproperty
	a_m1rd: assert property (p_m1rd)
		else $error("first mask read back wrong");
endmodule : tsm_checker
`default_nettype wire

// ---- testbench/tsm_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsm_host (
	input wire logic mclk, // Clock
	output logic psel, // Select
	output logic penable, // Enable
	output logic pwrite, // Direction
	output logic [11:0] paddr, // Address
	output logic [31:0] pwdata, // Write data
	output logic [3:0] pstrb, // Strobes
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr // Error
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// Starts one edge late so back-to-back calls never reassign psel in one step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= 4'hF;
		@(posedge mclk);
		penable <= 1'b1;
		// No cycle limit here: only the bench watchdog ends a wait for ready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : tsm_host
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
	localparam int SHORT = 40;
	localparam int LONG = 43;
	localparam int FAST = 7;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
	logic rx_mf_boundary, tx_mf_boundary, rx_link_bit_valid, rx_link_bit, tx_link_empty;
	logic rx_sig_strobe, bpv_pulse, zero_sub_codeword, line_bit_valid, line_bit_zero;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, rx_sig_value;
	logic [7:0] first_status_cond, q, b, r;
	logic [7:0] ev_x [7] = '{8'h80, 8'h40, 8'h08, 8'h01, 8'h14, 8'h12, 8'h14};
	logic [11:0] rst_a [6] = '{12'h1FC, 12'h1BC, 12'h08C, 12'h090, 12'h080, 12'h100};
	int err_total, n_checks, t0, gap;
	tsm_top #(.SEC_SHORT_CYC(SHORT), .SEC_LONG_CYC(LONG), .FAST_CYC(FAST)) DUT (.mclk, .rst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.first_status_cond, .rx_mf_boundary, .tx_mf_boundary, .rx_link_bit_valid, .rx_link_bit,
		.tx_link_empty, .rx_sig_strobe, .rx_sig_value, .bpv_pulse, .zero_sub_codeword,
		.line_bit_valid, .line_bit_zero, .irq);
	tsm_host host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m);
		host.xfer(1'b0, a, 8'h00, q, e);
		`CHK($sformatf("reg %0h", a), x, q & m)
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	// Clears the second status byte and waits for the tick interrupt to come back
	task automatic tick;
		wr(12'h084, 8'hFF);
		cyc(2);
		// A tick that never comes is caught by the watchdog as a failure
		while (irq !== 1'b1) begin
			@(posedge mclk);
		end
	endtask : tick
	task automatic sendb(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			rx_link_bit_valid <= 1'b1;
			rx_link_bit <= v[i];
			@(posedge mclk);
		end
		rx_link_bit_valid <= 1'b0;
	endtask : sendb
	function automatic logic [15:0] exp_cv(logic [2:0] c, int nb, int nc, int nz);
		exp_cv = 16'(nb - (c[1] ? nc : 0));
		if (c[0] && nz >= (c[1] ? 8 : 16)) exp_cv++;
	endfunction : exp_cv
	// Whole stimulus fits between two ticks, so the held count covers it exactly
	task automatic meas(input logic [2:0] c);
		int nb, nc, nz;
		logic [7:0] lo, hi;
		nb = 2 + int'($urandom % 12);
		nc = nb / 2;
		nz = int'($urandom % 2) * (c[1] ? 8 : 16);
		wr(12'h100, {5'h00, c});
		tick();
		first_status_cond[0] <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			bpv_pulse <= i < nb;
			zero_sub_codeword <= i < nc;
			line_bit_zero <= i < nz;
			line_bit_valid <= 1'b1;
			@(posedge mclk);
		end
		bpv_pulse <= 1'b0;
		zero_sub_codeword <= 1'b0;
		line_bit_zero <= 1'b0;
		first_status_cond[0] <= 1'b0;
		tick();
		host.xfer(1'b0, 12'h090, 8'h00, lo, e);
		host.xfer(1'b0, 12'h08C, 8'h00, hi, e);
		`CHK("count", exp_cv(c, nb, nc, nz), {hi, lo})
		cyc(8);
		rd(12'h090, 8'(exp_cv(c, nb, nc, nz)), 8'hFF);
	endtask : meas
	initial begin
		void'($urandom(79));
		{rst, rx_mf_boundary, tx_mf_boundary, rx_link_bit_valid, rx_link_bit} = 5'h10;
		{tx_link_empty, rx_sig_strobe, bpv_pulse, zero_sub_codeword} = 4'h0;
		{line_bit_valid, line_bit_zero, rx_sig_value, first_status_cond} = 14'h0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		for (int k = 0; k < 6; k++) rd(rst_a[k], tsm_pkg::RST_MASK, 8'hFF);
		host.xfer(1'b0, 12'h0C0, 8'h00, q, e);
		`CHK("unmapped", 1'b1, e)
		host.xfer(1'b0, 12'h081, 8'h00, q, e);
		`CHK("misaligned", 1'b1, e)
		wr(12'h08C, 8'h55);
		rd(12'h08C, 8'h00, 8'hFF);
		r = 8'($urandom);
		wr(12'h1FC, r);
		wr(12'h1BC, ~r);
		rd(12'h1FC, r, 8'hFF);
		rd(12'h1BC, ~r, 8'hFF);
		wr(12'h1BC, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(12'h1FC, 8'h01 << i);
			first_status_cond[i] <= 1'b1;
			cyc(2);
			first_status_cond[i] <= 1'b0;
			cyc(2);
			`CHK("irq set", 1'b1, irq)
			rd(12'h080, 8'h01 << i, 8'hFF);
			wr(12'h1FC, ~(8'h01 << i));
			cyc(2);
			`CHK("irq masked", 1'b0, irq)
			wr(12'h080, 8'hFF);
		end
		wr(12'h1FC, 8'h00);
		b = 8'($urandom) & 8'hFE;
		wr(12'h104, b);
		wr(12'h108, b ^ 8'h80);
		rx_sig_value <= 4'($urandom) | 4'h1;
		for (int k = 0; k < 7; k++) begin
			wr(12'h084, 8'hFF);
			if (k < 4) {rx_mf_boundary, tx_mf_boundary, tx_link_empty, rx_sig_strobe} <= 4'h8 >> k;
			else sendb(k == 5 ? 8'hFF : (k == 4 ? b : b ^ 8'h80));
			@(posedge mclk);
			{rx_mf_boundary, tx_mf_boundary, rx_sig_strobe} <= 3'h0;
			cyc(2);
			rd(12'h084, ev_x[k], 8'hDF);
		end
		wr(12'h1BC, 8'h20);
		tick();
		t0 = int'($time / 100);
		gap = 0;
		for (int k = 0; k < 3; k++) begin
			tick();
			`CHK("tick gap", 1'b1, (int'($time / 100) - t0) inside {SHORT, LONG})
			gap += int'($time / 100) - t0;
			t0 = int'($time / 100);
		end
		`CHK("tick cycle", SHORT * 2 + LONG, gap)
		rd(12'h084, 8'h20, 8'h20);
		for (int c = 0; c < 4; c++) meas(3'(c));
		bpv_pulse <= 1'b1;
		wr(12'h100, 8'h04);
		cyc(14);
		rd(12'h090, 8'(FAST), 8'hFF);
		bpv_pulse <= 1'b0;
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		finish_test();
	end
endmodule : testbench
bind tsm_top tsm_checker chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .irq);
`default_nettype wire
